// ### eeprom_loader.sv
// Purpose: fetch mode and detection parts from a two-wire serial memory
// Assumes: memory answers like a standard 8-kbit two-wire part
// Notes:   one read per part: start, address, repeated start, sequential read
//
// Functional notes
// - parameters come from external memory over clock and data wires
// - this block is link master and alone drives the serial clock
// - data line is shared; memory drives acknowledges and read data
// - random read addressing followed by sequential multi-byte read
// - memory holds fifteen parts; fourteen are per-mode
// - a newly detected mode fetches its part
// - fifteenth part gives detection data and error thresholds
// - parts one to fourteen map to modes zero to thirteen in order
// - panel timing bytes are read and delivered for output timing
// - last byte of a mode part is low eight bits of sum
// - first detection byte gives own serial address in low seven bits
`timescale 1ns/100ps
module eeprom_loader (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       modeValid,
    input  wire logic [3:0] modeNum,
    input  wire logic       sdaIn,
    output logic            sclOut,
    output logic            sdaOut,
    output logic            sdaOe,
    output logic            byteValid,
    output logic [9:0]      byteAddr,
    output logic [7:0]      byteData,
    output logic            loadDone,
    output logic            checksumErr,
    output logic            ackErr,
    output logic [6:0]      ownAddr,
    output logic            busy
);
    typedef enum logic [7:0] {
        S_IDLE  = 8'h01, S_START = 8'h02, S_SEND = 8'h04, S_ACKIN = 8'h08,
        S_RECV  = 8'h10, S_ACKOUT = 8'h20, S_STOP = 8'h40, S_DONE = 8'h80
    } state_e;

    // decode a memory byte address into the serial address byte
    function automatic logic [7:0] devByte(input logic [9:0] a, input logic rw);
        devByte = {eeprom_loader_pkg::MEM_ADDR_HI, 1'b0, a[9:8], rw};
    endfunction

    state_e      st_reg, st_next;
    logic [7:0]  tick_reg, tick_next;
    logic [1:0]  ph_reg, ph_next;
    logic [3:0]  bit_reg, bit_next;
    logic [7:0]  sh_reg, sh_next;
    logic [1:0]  step_reg, step_next;     // 0 addr+W, 1 word, 2 addr+R
    logic [9:0]  base_reg, base_next;
    logic [5:0]  cnt_reg, cnt_next;
    logic [5:0]  len_reg, len_next;
    logic [7:0]  sum_reg, sum_next;
    logic        detDone_reg, detDone_next;
    logic        pend_reg, pend_next;
    logic [3:0]  pmode_reg, pmode_next;
    logic        scl_reg, scl_next, sda_reg, sda_next, oe_reg, oe_next;
    logic        bv_reg, bv_next, ld_reg, ld_next, ck_reg, ck_next, ae_reg, ae_next;
    logic [9:0]  ba_reg, ba_next;
    logic [7:0]  bd_reg, bd_next;
    logic [6:0]  own_reg, own_next;
    logic        tick;
    logic        busy_reg, busy_next;

    assign tick = (tick_reg == eeprom_loader_pkg::QTR_COUNT);

    // sequencer: each bit is four quarter phases, clock high in phases 2 and 3
    always_comb begin
        st_next = st_reg; tick_next = tick ? 8'h00 : tick_reg + 8'h01;
        ph_next = ph_reg; bit_next = bit_reg; sh_next = sh_reg; step_next = step_reg;
        base_next = base_reg; cnt_next = cnt_reg; len_next = len_reg; sum_next = sum_reg;
        detDone_next = detDone_reg; pend_next = pend_reg; pmode_next = pmode_reg;
        scl_next = scl_reg; sda_next = sda_reg; oe_next = oe_reg;
        bv_next = 1'b0; ld_next = 1'b0; ck_next = ck_reg; ae_next = ae_reg;
        ba_next = ba_reg; bd_next = bd_reg; own_next = own_reg;
        // a mode report is latched so it is not lost while a part is loading
        if (modeValid && modeNum < eeprom_loader_pkg::MODE_PARTS) begin
            pend_next = 1'b1;
            pmode_next = modeNum;
        end
        case (st_reg)
            S_IDLE: begin
                scl_next = 1'b1; sda_next = 1'b1; oe_next = 1'b1;
                if (tick && (!detDone_reg || pend_reg)) begin
                    if (!detDone_reg) begin
                        base_next = eeprom_loader_pkg::DETECT_BASE;
                        len_next = eeprom_loader_pkg::DETECT_BYTES;
                    end else begin
                        base_next = {1'b0, pmode_reg, 5'h00};
                        len_next = eeprom_loader_pkg::PART_BYTES;
                        // a report in the very cycle the load starts is kept, set wins
                        pend_next = modeValid && (modeNum < eeprom_loader_pkg::MODE_PARTS);
                    end
                    step_next = 2'd0; ph_next = 2'd0; st_next = S_START;
                    cnt_next = 6'h00; sum_next = 8'h00; ck_next = 1'b0; ae_next = 1'b0;
                end
            end
            S_START: if (tick) begin
                ph_next = ph_reg + 2'd1;
                // a repeated start arrives with the line released and the clock low
                if (ph_reg == 2'd0) begin sda_next = 1'b1; oe_next = 1'b1; end
                if (ph_reg == 2'd1) scl_next = 1'b1;
                if (ph_reg == 2'd2) sda_next = 1'b0;           // fall with clock high
                if (ph_reg == 2'd3) begin
                    scl_next = 1'b0; st_next = S_SEND; bit_next = 4'd7; ph_next = 2'd0;
                    sh_next = (step_reg == 2'd2) ? devByte(base_reg, eeprom_loader_pkg::BIT_READ)
                                                 : devByte(base_reg, eeprom_loader_pkg::BIT_WRITE);
                end
            end
            S_SEND: if (tick) begin
                ph_next = ph_reg + 2'd1;
                if (ph_reg == 2'd0) begin sda_next = sh_reg[7]; oe_next = 1'b1; end
                if (ph_reg == 2'd1) scl_next = 1'b1;
                if (ph_reg == 2'd3) begin
                    scl_next = 1'b0; sh_next = {sh_reg[6:0], 1'b0};
                    if (bit_reg == 4'd0) st_next = S_ACKIN; else bit_next = bit_reg - 4'd1;
                end
            end
            S_ACKIN: if (tick) begin
                ph_next = ph_reg + 2'd1;
                if (ph_reg == 2'd0) oe_next = 1'b0;
                if (ph_reg == 2'd1) scl_next = 1'b1;
                if (ph_reg == 2'd2 && sdaIn) ae_next = 1'b1;
                if (ph_reg == 2'd3) begin
                    scl_next = 1'b0; bit_next = 4'd7;
                    if (ae_reg) st_next = S_STOP;
                    else if (step_reg == 2'd0) begin
                        step_next = 2'd1; st_next = S_SEND; sh_next = base_reg[7:0];
                    end else if (step_reg == 2'd1) begin
                        step_next = 2'd2; st_next = S_START; // repeated start
                    end else st_next = S_RECV;
                end
            end
            S_RECV: if (tick) begin
                ph_next = ph_reg + 2'd1;
                if (ph_reg == 2'd0) oe_next = 1'b0;
                if (ph_reg == 2'd1) scl_next = 1'b1;
                if (ph_reg == 2'd2) sh_next = {sh_reg[6:0], sdaIn};
                if (ph_reg == 2'd3) begin
                    scl_next = 1'b0;
                    if (bit_reg == 4'd0) st_next = S_ACKOUT; else bit_next = bit_reg - 4'd1;
                end
            end
            S_ACKOUT: if (tick) begin
                ph_next = ph_reg + 2'd1;
                if (ph_reg == 2'd0) begin
                    bv_next = 1'b1; ba_next = base_reg + {4'h0, cnt_reg}; bd_next = sh_reg;
                    if (cnt_reg != len_reg - 6'h01) sum_next = sum_reg + sh_reg;
                    else if (base_reg != eeprom_loader_pkg::DETECT_BASE && sh_reg != sum_reg)
                        ck_next = 1'b1;
                    if (cnt_reg == 6'h00 && base_reg == eeprom_loader_pkg::DETECT_BASE)
                        own_next = sh_reg[6:0];
                    oe_next = 1'b1;
                    sda_next = (cnt_reg == len_reg - 6'h01); // nack the last byte
                end
                if (ph_reg == 2'd1) scl_next = 1'b1;
                if (ph_reg == 2'd3) begin
                    scl_next = 1'b0; bit_next = 4'd7; cnt_next = cnt_reg + 6'h01;
                    st_next = (cnt_reg == len_reg - 6'h01) ? S_STOP : S_RECV;
                end
            end
            S_STOP: if (tick) begin
                ph_next = ph_reg + 2'd1;
                if (ph_reg == 2'd0) begin sda_next = 1'b0; oe_next = 1'b1; end
                if (ph_reg == 2'd1) scl_next = 1'b1;
                if (ph_reg == 2'd2) sda_next = 1'b1;       // rise with clock high
                if (ph_reg == 2'd3) st_next = S_DONE;
            end
            S_DONE: begin
                ld_next = !ae_reg; detDone_next = detDone_reg | !ae_reg;
                st_next = S_IDLE;
            end
            default: st_next = S_IDLE;
        endcase
        // status is registered so the pin never glitches on state decode
        busy_next = (st_next != S_IDLE);
    end

    // registers; clock enable low freezes everything
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= S_IDLE; tick_reg <= 8'h00; ph_reg <= 2'd0; bit_reg <= 4'd0;
            sh_reg <= 8'h00; step_reg <= 2'd0; base_reg <= 10'h000; cnt_reg <= 6'h00;
            len_reg <= 6'h00; sum_reg <= 8'h00; detDone_reg <= 1'b0; pend_reg <= 1'b0;
            pmode_reg <= 4'h0; scl_reg <= 1'b1; sda_reg <= 1'b1; oe_reg <= 1'b1;
            bv_reg <= 1'b0; ld_reg <= 1'b0; ck_reg <= 1'b0; ae_reg <= 1'b0;
            ba_reg <= 10'h000; bd_reg <= 8'h00; own_reg <= eeprom_loader_pkg::OWN_ADDR_RESET;
            busy_reg <= 1'b0;
        end else if (ce) begin
            st_reg <= st_next; tick_reg <= tick_next; ph_reg <= ph_next; bit_reg <= bit_next;
            sh_reg <= sh_next; step_reg <= step_next; base_reg <= base_next; cnt_reg <= cnt_next;
            len_reg <= len_next; sum_reg <= sum_next; detDone_reg <= detDone_next;
            pend_reg <= pend_next; pmode_reg <= pmode_next; scl_reg <= scl_next;
            sda_reg <= sda_next; oe_reg <= oe_next; bv_reg <= bv_next; ld_reg <= ld_next;
            ck_reg <= ck_next; ae_reg <= ae_next; ba_reg <= ba_next; bd_reg <= bd_next;
            own_reg <= own_next;
            busy_reg <= busy_next;
        end
    end

    assign sclOut = scl_reg;
    assign sdaOut = sda_reg;
    assign sdaOe = oe_reg;
    assign byteValid = bv_reg;
    assign byteAddr = ba_reg;
    assign byteData = bd_reg;
    assign loadDone = ld_reg;
    assign checksumErr = ck_reg;
    assign ackErr = ae_reg;
    assign ownAddr = own_reg;
    assign busy = busy_reg;

    // clock is only high while the data line is not changing, except in start and stop
    property p_data_stable;
        @(posedge mclk) disable iff (rst)
        (ce && $changed(sda_reg) && st_reg != S_START && st_reg != S_STOP) |-> !scl_reg;
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("data moved, clock high");
    sequence s_rise; $rose(sda_reg) ##0 scl_reg; endsequence
    property p_stop_only;
        @(posedge mclk) disable iff (rst) s_rise |-> (st_reg == S_STOP || st_reg == S_START);
    endproperty
    a_stop_only: assert property (p_stop_only) else $error("stray stop condition");
    property p_master_drives_clock;
        @(posedge mclk) disable iff (rst) (st_reg == S_IDLE) |-> scl_reg;
    endproperty
    a_master_drives_clock: assert property (p_master_drives_clock) else $error("clock low");
    property p_release_on_ack;
        @(posedge mclk) disable iff (rst) (st_reg == S_ACKIN && ph_reg != 2'd0) |-> !oe_reg;
    endproperty
    a_release_on_ack: assert property (p_release_on_ack) else $error("driving during ack");
    property p_mode_base;
        @(posedge mclk) disable iff (rst)
        (bv_reg && ba_reg < eeprom_loader_pkg::DETECT_BASE) |-> (ba_reg[4:0] == 5'(cnt_reg));
    endproperty
    a_mode_base: assert property (p_mode_base) else $error("byte address off part");
    property p_own_addr;
        @(posedge mclk) disable iff (rst)
        (bv_reg && ba_reg == eeprom_loader_pkg::DETECT_BASE) |-> own_reg == bd_reg[6:0];
    endproperty
    a_own_addr: assert property (p_own_addr) else $error("own address not taken");
    property p_done_pulse;
        @(posedge mclk) disable iff (rst) ld_reg |=> !ld_reg;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done held");
    property p_detect_first;
        @(posedge mclk) disable iff (rst)
        (bv_reg && !detDone_reg) |-> ba_reg >= eeprom_loader_pkg::DETECT_BASE;
    endproperty
    a_detect_first: assert property (p_detect_first) else $error("mode before detect part");
endmodule

// ### eeprom_loader_pkg.sv
// Purpose: constants for the serial memory parameter loader
// Assumes: 100 MHz mclk, memory mode parts of 32 bytes
// Notes:   detection base, part counts and sizes, and the own address reset value live here
package eeprom_loader_pkg;
    localparam int          CLK_MHZ        = 100;
    // serial clock rate; a slower memory part needs a lower value and loads take longer
    localparam int          SCL_KHZ        = 2500;
    // quarter of a serial clock period in mclk cycles
    localparam int          QTR_CYCLES     = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
    localparam logic [7:0]  QTR_COUNT      = 8'(QTR_CYCLES - 1);
    localparam logic [3:0]  MODE_PARTS     = 4'hE;
    localparam logic [5:0]  PART_BYTES     = 6'h20;
    localparam logic [9:0]  DETECT_BASE    = 10'h200;
    localparam logic [5:0]  DETECT_BYTES   = 6'h20;
    localparam logic [3:0]  MEM_ADDR_HI    = 4'hA;
    localparam logic [6:0]  OWN_ADDR_RESET = 7'h00;
    localparam logic        BIT_WRITE      = 1'b0;
    localparam logic        BIT_READ       = 1'b1;
endpackage

// ### serial_mem_model.sv
// Purpose: behavioural two-wire serial memory, far side of the loader
// Assumes: line has a pull-up; address 1010,A9,A8 then word byte A7..A0
// Notes:   nackDev makes the device byte go unanswered
`timescale 1ns/100ps
module serial_mem_model (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic nackDev,
    output logic      memOe,
    output logic      memOut
);
    logic [7:0] mem [0:1023];
    logic [7:0] sh;
    logic [9:0] ptr;
    int         bitN;
    logic       active, tx, isDev, mAck;
    // contents: a pattern per address, checksum byte closing each mode part
    initial begin
        int s;
        memOe = 1'b0; memOut = 1'b1; active = 1'b0; tx = 1'b0;
        isDev = 1'b0; mAck = 1'b0; bitN = 0; ptr = 10'h000; sh = 8'h00;
        for (int a = 0; a < 1024; a++) mem[a] = 8'(a) ^ 8'h5C;
        for (int p = 0; p < 14; p++) begin
            s = 0;
            for (int b = 0; b < 31; b++) s += mem[p*32+b];
            mem[p*32+31] = 8'(s);
        end
        mem[10'h200] = 8'hA5;
    end
    // clock is only received here, never driven
    always @(negedge sda) if (scl === 1'b1) begin
        active = 1'b1; isDev = 1'b1; tx = 1'b0; memOe = 1'b0;
        bitN = -1; // the clock fall that closes a start carries no data bit
    end
    always @(posedge sda) if (scl === 1'b1) begin
        active = 1'b0; memOe = 1'b0;
    end
    // sample while the clock is high
    always @(posedge scl) if (active) begin
        if (bitN < 8 && !tx) sh = {sh[6:0], sda};
        if (bitN == 8 && tx) mAck = !sda;
    end
    // drive only just after the clock falls
    always @(negedge scl) if (active) begin
        if (bitN < 7) begin
            bitN++;
            if (tx) memOut = mem[ptr][7-bitN];
        end else if (bitN == 7) begin
            bitN = 8;
            memOut = 1'b0;
            if (tx) memOe = 1'b0;
            else begin
                memOe = !(isDev && (sh[7:4] != 4'hA || nackDev));
                if (isDev) ptr[9:8] = sh[2:1];
                else ptr[7:0] = sh;
            end
        end else begin
            bitN = 0;
            if (tx && mAck) begin
                ptr = ptr + 10'h1; memOe = 1'b1; memOut = mem[ptr][7];
            end else if (!tx && isDev && sh[0] && memOe) begin
                tx = 1'b1; memOut = mem[ptr][7];
            end else begin
                if (!memOe) active = 1'b0;
                memOe = 1'b0; isDev = 1'b0;
            end
        end
    end
endmodule

// ### testbench.sv
// Purpose: self-checking bench for the serial memory parameter loader
// Assumes: one clock, loads take about 12.7k cycles each at a 2.5 MHz serial clock
// Notes:   byte data is judged against the memory model contents
`timescale 1ns/100ps
module testbench;
    logic       mclk, rst, ce, modeValid, nackDev, memOe, memOut;
    logic [3:0] modeNum;
    logic       sclOut, sdaOut, sdaOe, byteValid, loadDone, checksumErr, ackErr, busy;
    logic [9:0] byteAddr, expAddr;
    logic [7:0] byteData;
    logic [6:0] ownAddr;
    wire        sdaLine;
    int         fail_count = 0, n_checks = 0, nBytes = 0, starts = 0, stops = 0;
    // pull-up wire: any party driving low wins
    assign sdaLine = (sdaOe ? sdaOut : 1'b1) & (memOe ? memOut : 1'b1);
    eeprom_loader DUT (.mclk(mclk), .rst(rst), .ce(ce), .modeValid(modeValid),
        .modeNum(modeNum), .sdaIn(sdaLine), .sclOut(sclOut), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .byteValid(byteValid), .byteAddr(byteAddr), .byteData(byteData),
        .loadDone(loadDone), .checksumErr(checksumErr), .ackErr(ackErr),
        .ownAddr(ownAddr), .busy(busy));
    serial_mem_model mdl (.scl(sclOut), .sda(sdaLine), .nackDev(nackDev),
        .memOe(memOe), .memOut(memOut));
    initial begin mclk = 1'b0; forever #5 mclk = ~mclk; end
    task automatic chkBit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t flag %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chkVec(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t value %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // every delivered byte carries the next address and the stored value
    always @(posedge mclk) if (byteValid === 1'b1) begin
        chkVec(byteAddr, expAddr);
        chkVec({2'h0, byteData}, {2'h0, mdl.mem[expAddr]});
        expAddr <= expAddr + 10'h1;
        nBytes <= nBytes + 1;
    end
    // start and stop are the only data edges while the clock is high
    always @(negedge sdaLine) if (sclOut === 1'b1) starts++;
    always @(posedge sdaLine) if (sclOut === 1'b1) stops++;
    task automatic kick(input logic [3:0] m);
        @(negedge mclk) modeValid = 1'b1; modeNum = m;
        @(negedge mclk) modeValid = 1'b0;
    endtask
    task automatic runLoad(input logic [9:0] base, input logic [3:0] m, input logic go,
                           input logic sumErr);
        int s0, p0, i;
        s0 = starts; p0 = stops; nBytes = 0; expAddr = base; i = 0;
        if (go) kick(m);
        while (loadDone !== 1'b1 && i < 20000) begin @(negedge mclk); i++; end
        chkBit(loadDone, 1'b1);
        chkVec(10'(nBytes), 10'h020);
        chkVec(10'(starts - s0), 10'h002);
        chkVec(10'(stops - p0), 10'h001);
        chkBit(checksumErr, sumErr);
        chkBit(ackErr, 1'b0);
    endtask
    task automatic test_detect();
        runLoad(10'h200, 4'h0, 1'b0, 1'b0);
        chkVec({3'h0, ownAddr}, 10'h025);
        $display("test detect part done");
    endtask
    task automatic test_modes();
        kick(4'hE);
        repeat (20) @(negedge mclk);
        chkBit(busy, 1'b0);
        // with the clock enable low a mode report is neither taken nor acted on
        ce = 1'b0;
        kick(4'h3);
        repeat (20) @(negedge mclk);
        chkBit(busy, 1'b0);
        ce = 1'b1;
        repeat (20) @(negedge mclk);
        chkBit(busy, 1'b0);
        runLoad(10'h1A0, 4'hD, 1'b1, 1'b0);
        runLoad(10'h060, 4'h3, 1'b1, 1'b0);
        $display("test mode parts done");
    endtask
    task automatic test_sum();
        mdl.mem[10'h01F] = mdl.mem[10'h01F] + 8'h01;
        runLoad(10'h000, 4'h0, 1'b1, 1'b1);
        $display("test bad checksum done");
    endtask
    task automatic test_nack();
        int i, p0;
        nackDev = 1'b1; p0 = stops; i = 0;
        kick(4'h2);
        while (ackErr !== 1'b1 && i < 20000) begin @(negedge mclk); i++; end
        chkBit(ackErr, 1'b1);
        repeat (2000) @(negedge mclk);
        chkVec(10'(stops - p0), 10'h001);
        chkBit(busy, 1'b0);
        nackDev = 1'b0;
        $display("test unanswered device byte done");
    endtask
    initial begin
        rst = 1'b1; ce = 1'b1; modeValid = 1'b0; modeNum = 4'h0; nackDev = 1'b0;
        expAddr = 10'h000;
        repeat (3) @(negedge mclk);
        chkBit(sclOut, 1'b1);
        rst = 1'b0;
        test_detect();
        test_modes();
        test_sum();
        test_nack();
        close_out();
    end
    // watchdog at 80k cycles, well past four full loads and the short refused one
    initial begin #800000; fail_count++; close_out(); end
endmodule
